// ---- logic/pic_pkg.sv ----
// Behaviour
// - seventeen request sources, twelve pin and five peripheral, land on sixteen vectors.
// - comparator request and port A pin 6 request share one vector.
// - eight pin requests take rising or falling edge; four take both edges.
// - each vector individually set to one of three levels or disabled.
// - enable pair 00 off, 01 level 1, 10 level 2, 11 level 3.
// - vector is two bytes, high byte at even address, low byte next.
// - group-1 high enable at FC4H: bit 6 shared request, bit 7 pin 7.
// - port-select bits pick port A or port D pin for bits 5 to 0.
// - shared select bit 6 at FCEH: clear pin 6, set comparator.
// - shared requests are edge triggered; switching source may raise a request.
// - in polled handling, priority and enable logic leave flags untouched.
package pic_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_VEC = 16;
  localparam int VEC_IDX_W = 4;
  localparam int NUM_GRP_PIN = 8;
  localparam int NUM_DUAL = 4;
  localparam int NUM_PERIPH = 4;
  localparam int NUM_PORT_SEL = 6;
  localparam logic [ADDR_W-1:0] ADDR_FLAG1 = 12'hFC0;
  localparam logic [ADDR_W-1:0] ADDR_FLAG2 = 12'hFC1;
  localparam logic [ADDR_W-1:0] ADDR_MASK1 = 12'hFC2;
  localparam logic [ADDR_W-1:0] ADDR_MASK2 = 12'hFC3;
  localparam logic [ADDR_W-1:0] ADDR_EN1_HI = 12'hFC4;
  localparam logic [ADDR_W-1:0] ADDR_EN1_LO = 12'hFC5;
  localparam logic [ADDR_W-1:0] ADDR_EN2_HI = 12'hFC6;
  localparam logic [ADDR_W-1:0] ADDR_EN2_LO = 12'hFC7;
  localparam logic [ADDR_W-1:0] ADDR_PORT_SEL = 12'hFC8;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = 12'hFC9;
  localparam logic [ADDR_W-1:0] ADDR_SHARED_SEL = 12'hFCE;
  localparam int SHARED_BIT = 6;
  localparam int PIN7_BIT = 7;
  localparam logic [DATA_W-1:0] SHARED_SEL_MASK = 8'h40;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [15:0] VEC_BASE_DEF = 16'h0008;
  typedef enum logic [1:0] {
    PIC_LVL_OFF,
    PIC_LVL_LOW,
    PIC_LVL_NOM,
    PIC_LVL_HIGH
  } pic_level_e;
  function automatic pic_level_e pic_decode_level(input logic hi,
                                                  input logic lo);
    return pic_level_e'({hi, lo});
  endfunction
endpackage

// ---- logic/pic_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module pic_edge_detect import pic_pkg::*; #(
  parameter int W = 8,
  parameter bit SYNC = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] sig,
  input wire logic [W-1:0] fall_sel,
  input wire logic [W-1:0] both_sel,
  output logic [W-1:0] edge_pulse
);
  logic [W-1:0] meta_q;
  logic [W-1:0] cur_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  // two flops for pins; same-clock sources pass straight through
  generate
    if (SYNC) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          meta_q <= '0;
          cur_q <= '0;
        end else begin
          meta_q <= sig;
          cur_q <= meta_q;
        end
      end
    end else begin : g_nosync
      assign meta_q = '0;
      assign cur_q = sig;
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= cur_q;
    end
  end

  assign rise = cur_q & ~prev_q;
  assign fall = ~cur_q & prev_q;
  assign edge_pulse = (both_sel & (rise | fall)) |
                      (~both_sel & ~fall_sel & rise) |
                      (~both_sel & fall_sel & fall);
endmodule
`default_nettype wire

// ---- logic/pic_priority_pick.sv ----
`timescale 1ns/1ps
`default_nettype none
module pic_priority_pick import pic_pkg::*; #(
  parameter int N = NUM_VEC,
  parameter int IW = VEC_IDX_W
) (
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0] lvl_hi,
  input wire logic [N-1:0] lvl_lo,
  output logic found,
  output logic [IW-1:0] idx,
  output pic_level_e lvl
);
  // descending scan with >= so the lowest index wins a tie
  always_comb begin
    found = 1'b0;
    idx = '0;
    lvl = PIC_LVL_OFF;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i] && pic_decode_level(lvl_hi[i], lvl_lo[i]) != PIC_LVL_OFF
          && pic_decode_level(lvl_hi[i], lvl_lo[i]) >= lvl) begin
        found = 1'b1;
        idx = IW'(i);
        lvl = pic_decode_level(lvl_hi[i], lvl_lo[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/pic_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module pic_controller import pic_pkg::*; #(
  parameter logic [15:0] VEC_BASE = VEC_BASE_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q,
  input wire logic [NUM_GRP_PIN-1:0] port_a_pin,
  input wire logic [NUM_PORT_SEL-1:0] port_d_pin,
  input wire logic [NUM_DUAL-1:0] port_c_pin,
  input wire logic cmp_out,
  input wire logic [NUM_PERIPH-1:0] periph_req,
  input wire logic cpu_ack,
  output logic irq_q,
  output logic vec_valid_q,
  output logic [VEC_IDX_W-1:0] vec_index_q,
  output pic_level_e vec_level_q,
  output logic [15:0] vec_msb_addr_q,
  output logic [15:0] vec_lsb_addr_q
);
  logic [DATA_W-1:0] flag1_q, flag2_q;
  logic [DATA_W-1:0] mask1_q, mask2_q;
  logic [DATA_W-1:0] en1_hi_q, en1_lo_q, en2_hi_q, en2_lo_q;
  logic [NUM_PORT_SEL-1:0] port_sel_q;
  logic [DATA_W-1:0] edge_sel_q;
  logic [DATA_W-1:0] shared_sel_q;
  logic [NUM_GRP_PIN-1:0] grp_src;
  logic [NUM_GRP_PIN-1:0] grp_edge;
  logic [NUM_DUAL-1:0] dual_edge;
  logic [NUM_PERIPH-1:0] periph_edge;
  logic [NUM_VEC-1:0] vec_edge;
  logic [NUM_VEC-1:0] flags;
  logic [NUM_VEC-1:0] en_hi, en_lo;
  logic [NUM_VEC-1:0] pend;
  logic [NUM_VEC-1:0] ack_clr;
  logic [NUM_VEC-1:0] wr_clr;
  logic pick_found;
  logic [VEC_IDX_W-1:0] pick_idx;
  pic_level_e pick_lvl;
  logic [15:0] pick_msb;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    return reg_wr && reg_addr == a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // request sources
  always_comb begin
    for (int i = 0; i < NUM_PORT_SEL; i++) begin
      grp_src[i] = port_sel_q[i] ? port_d_pin[i] : port_a_pin[i];
    end
    // shared vector fed by one source only, chosen before the edge logic
    grp_src[SHARED_BIT] = shared_sel_q[SHARED_BIT] ? cmp_out
                                                   : port_a_pin[SHARED_BIT];
    grp_src[PIN7_BIT] = port_a_pin[PIN7_BIT];
  end

  pic_edge_detect #(.W(NUM_GRP_PIN), .SYNC(1'b1)) u_grp_edge (
    .core_clk(core_clk),
    .rst(rst),
    .sig(grp_src),
    .fall_sel(edge_sel_q),
    .both_sel('0),
    .edge_pulse(grp_edge)
  );

  pic_edge_detect #(.W(NUM_DUAL), .SYNC(1'b1)) u_dual_edge (
    .core_clk(core_clk),
    .rst(rst),
    .sig(port_c_pin),
    .fall_sel('0),
    .both_sel('1),
    .edge_pulse(dual_edge)
  );

  pic_edge_detect #(.W(NUM_PERIPH), .SYNC(1'b0)) u_periph_edge (
    .core_clk(core_clk),
    .rst(rst),
    .sig(periph_req),
    .fall_sel('0),
    .both_sel('0),
    .edge_pulse(periph_edge)
  );

  // twelve pins plus five peripherals onto sixteen vectors
  assign vec_edge = {periph_edge, dual_edge, grp_edge};

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en1_hi_q <= REG_RESET;
      en1_lo_q <= REG_RESET;
      en2_hi_q <= REG_RESET;
      en2_lo_q <= REG_RESET;
    end else begin
      if (wr_hit(ADDR_EN1_HI)) en1_hi_q <= reg_wdata;
      if (wr_hit(ADDR_EN1_LO)) en1_lo_q <= reg_wdata;
      if (wr_hit(ADDR_EN2_HI)) en2_hi_q <= reg_wdata;
      if (wr_hit(ADDR_EN2_LO)) en2_lo_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask1_q <= REG_RESET;
      mask2_q <= REG_RESET;
      port_sel_q <= '0;
      edge_sel_q <= REG_RESET;
      shared_sel_q <= REG_RESET;
    end else begin
      if (wr_hit(ADDR_MASK1)) mask1_q <= reg_wdata;
      if (wr_hit(ADDR_MASK2)) mask2_q <= reg_wdata;
      if (wr_hit(ADDR_PORT_SEL)) port_sel_q <= reg_wdata[NUM_PORT_SEL-1:0];
      if (wr_hit(ADDR_EDGE_SEL)) edge_sel_q <= reg_wdata;
      // reserved bits never stored
      if (wr_hit(ADDR_SHARED_SEL)) begin
        shared_sel_q <= reg_wdata & SHARED_SEL_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky request flags, set wins over clear
  assign flags = {flag2_q, flag1_q};
  assign en_hi = {en2_hi_q, en1_hi_q};
  assign en_lo = {en2_lo_q, en1_lo_q};
  assign pend = flags & {mask2_q, mask1_q};

  always_comb begin
    ack_clr = '0;
    if (vec_valid_q && cpu_ack) begin
      ack_clr[vec_index_q] = 1'b1;
    end
    wr_clr = '0;
    if (wr_hit(ADDR_FLAG1)) wr_clr[DATA_W-1:0] = reg_wdata;
    if (wr_hit(ADDR_FLAG2)) wr_clr[NUM_VEC-1:DATA_W] = reg_wdata;
  end

  // flags latch whatever the enables say, so polling still works
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag1_q <= REG_RESET;
      flag2_q <= REG_RESET;
    end else begin
      {flag2_q, flag1_q} <= (flags & ~(ack_clr | wr_clr)) | vec_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration and vector presentation
  pic_priority_pick #(.N(NUM_VEC), .IW(VEC_IDX_W)) u_pick (
    .pend(pend),
    .lvl_hi(en_hi),
    .lvl_lo(en_lo),
    .found(pick_found),
    .idx(pick_idx),
    .lvl(pick_lvl)
  );

  assign pick_msb = VEC_BASE + 16'({pick_idx, 1'b0});

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
      vec_valid_q <= 1'b0;
      vec_index_q <= '0;
      vec_level_q <= PIC_LVL_OFF;
      vec_msb_addr_q <= VEC_BASE;
      vec_lsb_addr_q <= VEC_BASE + 16'h0001;
    end else begin
      irq_q <= pick_found;
      vec_valid_q <= pick_found;
      vec_index_q <= pick_idx;
      vec_level_q <= pick_lvl;
      vec_msb_addr_q <= pick_msb;
      vec_lsb_addr_q <= pick_msb + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= REG_RESET;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_FLAG1) reg_rdata_q <= flag1_q;
      else if (reg_addr == ADDR_FLAG2) reg_rdata_q <= flag2_q;
      else if (reg_addr == ADDR_MASK1) reg_rdata_q <= mask1_q;
      else if (reg_addr == ADDR_MASK2) reg_rdata_q <= mask2_q;
      else if (reg_addr == ADDR_EN1_HI) reg_rdata_q <= en1_hi_q;
      else if (reg_addr == ADDR_EN1_LO) reg_rdata_q <= en1_lo_q;
      else if (reg_addr == ADDR_EN2_HI) reg_rdata_q <= en2_hi_q;
      else if (reg_addr == ADDR_EN2_LO) reg_rdata_q <= en2_lo_q;
      else if (reg_addr == ADDR_PORT_SEL) reg_rdata_q <= {2'h0, port_sel_q};
      else if (reg_addr == ADDR_EDGE_SEL) reg_rdata_q <= edge_sel_q;
      else if (reg_addr == ADDR_SHARED_SEL) reg_rdata_q <= shared_sel_q;
      else reg_rdata_q <= REG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_shared_write;
    reg_wr && reg_addr == ADDR_SHARED_SEL;
  endsequence

  sequence s_shared_read;
    reg_rd && reg_addr == ADDR_SHARED_SEL;
  endsequence

  a_shared_reserved_zero: assert property (
    s_shared_write |=> (shared_sel_q & ~SHARED_SEL_MASK) == 8'h00
      && shared_sel_q[SHARED_BIT] == $past(reg_wdata[SHARED_BIT]))
    else $error("shared select reserved bits not zero");

  a_shared_read_back: assert property (
    s_shared_write ##1 (s_shared_read and !reg_wr)
      |=> reg_rdata_q == ($past(reg_wdata, 2) & SHARED_SEL_MASK))
    else $error("shared select read back wrong");

  a_shared_source: assert property (
    grp_src[SHARED_BIT] == (shared_sel_q[SHARED_BIT] ? cmp_out
                                                     : port_a_pin[SHARED_BIT]))
    else $error("shared vector not fed by selected source");

  a_port_select: assert property (
    port_sel_q[0] |-> grp_src[0] == port_d_pin[0])
    else $error("port select not applied");

  a_hi_enable_store: assert property (
    reg_wr && reg_addr == ADDR_EN1_HI
      |=> en1_hi_q[SHARED_BIT] == $past(reg_wdata[SHARED_BIT])
        && en1_hi_q[PIN7_BIT] == $past(reg_wdata[PIN7_BIT]))
    else $error("group-1 high enable not stored");

  a_edge_sets_flag: assert property (
    |vec_edge |=> (flags & $past(vec_edge)) == $past(vec_edge))
    else $error("request edge lost");

  a_dual_both_edges: assert property (
    $fell(u_dual_edge.cur_q[0]) |-> dual_edge[0])
    else $error("dual edge request missed a fall");

  a_irq_follows: assert property (
    pick_found |=> irq_q && vec_level_q != PIC_LVL_OFF)
    else $error("enabled pending request did not raise irq");

  a_irq_off_disabled: assert property (
    (en_hi == '0 && en_lo == '0) |=> !irq_q)
    else $error("irq raised with all requests disabled");

  a_vec_top_level: assert property (
    vec_valid_q |-> vec_level_q == pic_decode_level(
      $past(en_hi[pick_idx]), $past(en_lo[pick_idx])))
    else $error("presented vector level wrong");

  a_vec_byte_pair: assert property (
    vec_valid_q |-> !vec_msb_addr_q[0]
      && vec_lsb_addr_q == vec_msb_addr_q + 16'h0001)
    else $error("vector byte addresses not an even pair");

  a_ack_clears: assert property (
    vec_valid_q && cpu_ack && !vec_edge[vec_index_q]
      |=> !flags[$past(vec_index_q)])
    else $error("acknowledged request not cleared");

  a_vec_pending: assert property (
    vec_valid_q |-> $past(pend[pick_idx]))
    else $error("presented vector was not pending");

  a_masked_no_irq: assert property (
    (pend & (en_hi | en_lo)) == 16'h0000 |=> !irq_q)
    else $error("irq raised with no enabled pending request");

  a_flag_write_clear: assert property (
    |wr_clr && (wr_clr & vec_edge) == 16'h0000
      |=> (flags & $past(wr_clr)) == 16'h0000)
    else $error("written flag not cleared");

  a_pin_rising_edge: assert property (
    $rose(u_grp_edge.cur_q[PIN7_BIT]) && !edge_sel_q[PIN7_BIT]
      |-> grp_edge[PIN7_BIT])
    else $error("selected rising edge missed");

  // ack of the only pending flag with no new edge beside it
  sequence s_last_ack;
    vec_valid_q && cpu_ack && vec_edge == 16'h0000
      && flags == (16'h0001 << vec_index_q);
  endsequence

  a_ack_drops_irq: assert property (
    s_last_ack |-> ##2 !irq_q)
    else $error("irq still high after last request acknowledged");
endmodule
`default_nettype wire

// ---- testbench/pic_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model import pic_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irq_q,
  input wire logic serve,
  input wire logic [3:0] ack_delay,
  output logic cpu_ack
);
  int cnt;
  // hold-off after each ack: irq and vector settle two cycles later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      cnt <= 0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      cnt <= -3;
    end else if (cnt < 0) begin
      cnt <= cnt + 1;
    end else if (!(serve && irq_q)) begin
      cnt <= 0;
    end else if (cnt >= int'(ack_delay)) begin
      cpu_ack <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/priority_interrupt_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_tb import pic_pkg::*; ;
  typedef struct packed {
    logic [3:0] vec;
    logic [1:0] code;
  } pic_row_s;
  localparam pic_row_s ROWS [8] = '{'{4'hC, 2'h0}, '{4'hD, 2'h1},
    '{4'hE, 2'h2}, '{4'hF, 2'h3}, '{4'h7, 2'h2}, '{4'h6, 2'h3},
    '{4'h0, 2'h1}, '{4'h9, 2'h3}};
  localparam int ORDER [5] = '{6, 15, 7, 14, 13};
  logic core_clk, rst, reg_wr, reg_rd, cmp_out, cpu_ack, serve, irq_q;
  logic vec_valid_q;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_q, rd_val;
  logic [7:0] port_a_pin;
  logic [5:0] port_d_pin;
  logic [3:0] port_c_pin, periph_req, ack_delay, vec_index_q;
  pic_level_e vec_level_q;
  logic [15:0] vec_msb_addr_q, vec_lsb_addr_q, en_hi, en_lo;
  logic [3:0] acked [$];
  int miscompares, checks_done, base;

  pic_controller #(.VEC_BASE(VEC_BASE_DEF)) u_dut (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .port_a_pin(port_a_pin), .port_d_pin(port_d_pin),
    .port_c_pin(port_c_pin), .cmp_out(cmp_out), .periph_req(periph_req),
    .cpu_ack(cpu_ack), .irq_q(irq_q), .vec_valid_q(vec_valid_q),
    .vec_index_q(vec_index_q), .vec_level_q(vec_level_q),
    .vec_msb_addr_q(vec_msb_addr_q), .vec_lsb_addr_q(vec_lsb_addr_q));
  pic_cpu_model u_cpu (.core_clk(core_clk), .rst(rst), .irq_q(irq_q),
    .serve(serve), .ack_delay(ack_delay), .cpu_ack(cpu_ack));

  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata_q;
  endtask
  task automatic set_en(input int v, input logic [1:0] c);
    logic [11:0] a;
    logic [3:0] s;
    a = (v < 8) ? ADDR_EN1_HI : ADDR_EN2_HI;
    s = (v < 8) ? 4'h0 : 4'h8;
    en_hi[v] = c[1];
    en_lo[v] = c[0];
    wr(a, en_hi[s+:8]);
    wr(a + 12'h001, en_lo[s+:8]);
    rd(a);
    chk("enable_hi", 16'(en_hi[s+:8]), 16'(rd_val));
  endtask
  // vector 0 is routed to port D by the port select
  task automatic drive(input int v, input logic lv);
    if (v == 0) port_d_pin[0] <= lv;
    else if (v < 8) port_a_pin[v] <= lv;
    else if (v < 12) port_c_pin[v-8] <= lv;
    else periph_req[v-12] <= lv;
  endtask
  task automatic wait_irq(input logic e);
    int i;
    for (i = 0; i < 12 && irq_q !== e; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("irq", 16'(e), 16'(irq_q));
  endtask
  task automatic chk_vec(input int v, input logic [1:0] c);
    chk("vec_valid", 16'h0001, 16'(vec_valid_q));
    chk("vec_index", 16'(v), 16'(vec_index_q));
    chk("vec_level", 16'(c), 16'(vec_level_q));
    chk("msb_addr", VEC_BASE_DEF + 16'(2*v), vec_msb_addr_q);
    chk("lsb_addr", VEC_BASE_DEF + 16'(2*v+1), vec_lsb_addr_q);
  endtask
  task automatic serve_n(input int n);
    int i;
    i = acked.size() + n;
    serve <= 1'b1;
    for (int k = 0; k < 300 && acked.size() < i; k++) @(posedge core_clk);
    serve <= 1'b0;
    chk("served", 16'(i), 16'(acked.size()));
  endtask

  ////////////////////////////////////////
  always @(posedge core_clk) if (cpu_ack === 1'b1) acked.push_back(vec_index_q);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, cmp_out, serve} = '0;
    {reg_addr, reg_wdata, port_a_pin, port_d_pin} = '0;
    {port_c_pin, periph_req, ack_delay, en_hi, en_lo} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("msb_reset", VEC_BASE_DEF, vec_msb_addr_q);
    chk("lsb_reset", VEC_BASE_DEF + 16'h0001, vec_lsb_addr_q);
    rd(ADDR_SHARED_SEL);
    chk("shared_sel_reset", 16'h0000, 16'(rd_val));
    wr(12'hFCA, 8'h5A);
    rd(12'hFCA);
    chk("unmapped", 16'h0000, 16'(rd_val));
    wr(ADDR_MASK1, 8'hFF);
    wr(ADDR_MASK2, 8'hFF);
    wr(ADDR_PORT_SEL, 8'h01);
    foreach (ROWS[r]) begin
      ack_delay <= 4'(r);
      set_en(ROWS[r].vec, ROWS[r].code);
      drive(ROWS[r].vec, 1'b1);
      if (ROWS[r].code == 2'b00) begin
        idle(8);
        chk("irq_off", 16'h0000, 16'(irq_q));
        rd(ADDR_FLAG2);
        chk("poll_flag", 16'h0010, 16'(rd_val));
        wr(ADDR_FLAG2, 8'h10);
      end else begin
        wait_irq(1'b1);
        chk_vec(ROWS[r].vec, ROWS[r].code);
        serve_n(1);
        wait_irq(1'b0);
      end
    end
    wr(ADDR_EDGE_SEL, 8'h01);
    {port_a_pin, port_d_pin, port_c_pin, periph_req} <= '0;
    idle(8);
    chk_vec(9, 2'h3);
    serve_n(2);
    chk("falling_sel", 16'h0000, 16'(acked[acked.size()-1]));
    wait_irq(1'b0);
    rd(ADDR_FLAG1);
    chk("no_rise_flag", 16'h0000, 16'(rd_val));
    wr(ADDR_MASK2, 8'h00);
    periph_req <= 4'hE;
    idle(6);
    chk("masked", 16'h0000, 16'(irq_q));
    port_a_pin <= 8'hC0;
    idle(8);
    chk_vec(6, 2'h3);
    wr(ADDR_MASK2, 8'hF0);
    base = acked.size();
    serve_n(5);
    foreach (ORDER[i]) chk("order", 16'(ORDER[i]), 16'(acked[base+i]));
    cmp_out <= 1'b1;
    idle(8);
    chk("cmp_unrouted", 16'h0000, 16'(irq_q));
    set_en(6, 2'h0);
    port_a_pin <= 8'h80;
    idle(6);
    // write then read back to back
    @(posedge core_clk);
    reg_addr <= ADDR_SHARED_SEL;
    reg_wdata <= 8'h40;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("shared_sel", 16'h0040, 16'(reg_rdata_q));
    idle(6);
    rd(ADDR_FLAG1);
    chk("switch_flag", 16'h0040, 16'(rd_val));
    chk("switch_irq", 16'h0000, 16'(irq_q));
    wr(ADDR_FLAG1, 8'h40);
    set_en(6, 2'h3);
    cmp_out <= 1'b0;
    idle(6);
    cmp_out <= 1'b1;
    wait_irq(1'b1);
    chk_vec(6, 2'h3);
    serve_n(1);
    wait_irq(1'b0);
    port_a_pin <= 8'hC0;
    idle(8);
    chk("pin6_unrouted", 16'h0000, 16'(irq_q));
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(ADDR_EN1_HI);
    chk("en_after_reset", 16'h0000, 16'(rd_val));
    end_sim();
  end
endmodule
`default_nettype wire
